// ---- shared/ref_input_defs.svh ----
// Constants for the reference-clock input stage
`ifndef REF_INPUT_DEFS_SVH
`define REF_INPUT_DEFS_SVH

// Mode codes
`define MODE_DIFF 2'h0
`define MODE_DUAL_SE 2'h1
`define MODE_DIFF_PIN 2'h2
// Index offset of the negative pin clock
`define NEG_INDEX_OFFSET 4'h8
// Divider field holds ratio minus one; smallest legal field
`define DIV_FIELD_MIN 16'h0001
`define DIV_FIELD_RESET 16'h0001
// Rate limits in MHz
`define LOOP_MAX_MHZ 150
`define DIFF_MAX_MHZ 1000
`define SE_MAX_MHZ 250
`endif

// ---- shared/ref_input_pkg.sv ----
// Types for the reference-clock input stage
package ref_input_pkg;
    // Nominal frequency as numerator over denominator, in hertz
    typedef struct packed {
        logic [47:0] num;
        logic [15:0] den;
    } nominal_freq_t;
    // Per-path settings
    typedef struct packed {
        logic enable;
        logic invert;
        logic bypass;
        logic sync_role;
        logic [15:0] div_m1;
    } path_cfg_t;
endpackage

// ---- logic/ref_input_stage.sv ----
// Reference-clock input stage: mode mapping, edge select, dividers
`include "ref_input_defs.svh"
module ref_input_stage #(
    // Stage numbering and mixed-mode support
    parameter logic [3:0] STAGE_INDEX = 4'h0,
    parameter bit MIXED_OK = 1'b1,
    parameter logic [3:0] MIXED_INDEX = 4'h8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Clock pins from outside
    input wire logic positive_input_pin,
    input wire logic negative_input_pin,
    input wire logic gpio_input_pin,
    // Configuration
    input wire logic [1:0] mode,
    input wire logic rx_nmos,
    input wire ref_input_pkg::nominal_freq_t input_nominal_frequency,
    input wire ref_input_pkg::path_cfg_t path_cfg [2],
    // Towards the loop logic
    output logic [1:0] clk_pulse_q,
    output logic [1:0] sync_pulse_q,
    output logic [3:0] clk_index_q [2],
    output logic [1:0] path_active_q,
    output logic rx_nmos_q,
    output logic [1:0] mode_q,
    output ref_input_pkg::nominal_freq_t nominal_freq_q
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] pin_s1_q; // First stage, read only by second
    logic [2:0] pin_s2_q; // Safe sampled levels
    logic [2:0] pin_s3_q; // Previous level for edge detection

    // Two flip-flops before any logic
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end else begin
            pin_s1_q <= {gpio_input_pin, negative_input_pin, positive_input_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    logic [1:0] eff_mode; // Mode after legality check
    logic [1:0] src_now; // Current level of each path source
    logic [1:0] src_prev; // Previous level of each path source
    logic [1:0] path_used; // Path exists in this mode
    logic [3:0] idx [2]; // Internal clock index per path

    // Mixed mode falls back to differential on stages without it
    always_comb begin
        eff_mode = mode;
        if (mode == `MODE_DIFF_PIN && !MIXED_OK) begin
            eff_mode = `MODE_DIFF;
        end else if (mode == 2'h3) begin
            eff_mode = `MODE_DIFF;
        end
    end

    // Route sources and assign indices
    always_comb begin
        src_now[0] = pin_s2_q[0];
        src_prev[0] = pin_s3_q[0];
        idx[0] = STAGE_INDEX;
        src_now[1] = 1'b0;
        src_prev[1] = 1'b0;
        idx[1] = STAGE_INDEX;
        path_used = 2'b01;
        unique case (eff_mode)
            `MODE_DUAL_SE: begin
                // Negative pin stands alone
                src_now[1] = pin_s2_q[1];
                src_prev[1] = pin_s3_q[1];
                idx[1] = STAGE_INDEX + `NEG_INDEX_OFFSET;
                path_used = 2'b11;
            end
            `MODE_DIFF_PIN: begin
                // Pin input alongside the pair
                src_now[1] = pin_s2_q[2];
                src_prev[1] = pin_s3_q[2];
                idx[1] = MIXED_INDEX;
                path_used = 2'b11;
            end
            default: begin
                path_used = 2'b01; // Differential only
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-path edge select and divider
    logic [15:0] div_cnt_q [2]; // Selected edges counted so far
    logic [1:0] edge_hit; // Selected edge seen this cycle
    logic [1:0] div_out; // Divided or bypassed event
    logic [1:0] live; // Path enabled and present

    // One copy of edge select and divider per path
    for (genvar p = 0; p < 2; p++) begin : g_path
        logic [15:0] field; // Ratio minus one, clamped to 1 minimum

        // Invert ahead of the divider for falling edge
        always_comb begin
            live[p] = path_cfg[p].enable && path_used[p];
            edge_hit[p] = live[p] && ((src_now[p] ^ path_cfg[p].invert) &&
                                      !(src_prev[p] ^ path_cfg[p].invert));
            field = (path_cfg[p].div_m1 < `DIV_FIELD_MIN) ? `DIV_FIELD_MIN : path_cfg[p].div_m1;
            // Pin path never divides
            if (path_cfg[p].bypass || (p == 1 && eff_mode == `MODE_DIFF_PIN)) begin
                div_out[p] = edge_hit[p];
            end else begin
                div_out[p] = edge_hit[p] && (div_cnt_q[p] >= field);
            end
        end

        // Count selected edges, held at zero while disabled
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                div_cnt_q[p] <= 16'h0000;
            end else if (!live[p] || path_cfg[p].bypass) begin
                div_cnt_q[p] <= 16'h0000;
            end else if (edge_hit[p]) begin
                div_cnt_q[p] <= (div_cnt_q[p] >= field) ? 16'h0000 : div_cnt_q[p] + 16'h0001;
            end
        end

        // Deliver event as clock or as sync pulse
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                clk_pulse_q[p] <= 1'b0;
                sync_pulse_q[p] <= 1'b0;
                clk_index_q[p] <= 4'h0;
                path_active_q[p] <= 1'b0;
            end else begin
                clk_pulse_q[p] <= div_out[p] && !path_cfg[p].sync_role;
                sync_pulse_q[p] <= div_out[p] && path_cfg[p].sync_role;
                clk_index_q[p] <= idx[p];
                path_active_q[p] <= live[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stage-wide settings
    // Receiver type only reaches the buffer in differential use
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_nmos_q <= 1'b0;
            mode_q <= `MODE_DIFF;
            nominal_freq_q <= '0;
        end else begin
            rx_nmos_q <= (eff_mode == `MODE_DUAL_SE) ? 1'b0 : rx_nmos;
            mode_q <= eff_mode;
            nominal_freq_q <= input_nominal_frequency;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // All checks sleep while reset is low
    // Each label carries the rule that it guards
    // Clamped ratio field of path 0, for the ratio check
    logic [15:0] field_0_chk;
    assign field_0_chk = (path_cfg[0].div_m1 < `DIV_FIELD_MIN) ? `DIV_FIELD_MIN : path_cfg[0].div_m1;

    // Disabled path 0 stays silent
    AST_DISABLED_QUIET:
    assert property (@(posedge clk) disable iff (!resetn)
        !live[0] |=> !clk_pulse_q[0] && !sync_pulse_q[0])
        else $error("disabled path produced an edge");
    // Disabled path 1 stays silent
    AST_DISABLED_QUIET1:
    assert property (@(posedge clk) disable iff (!resetn)
        !live[1] |=> !clk_pulse_q[1] && !sync_pulse_q[1])
        else $error("disabled second path produced an edge");
    // Divider of a disabled path 1 sits at zero
    AST_DIV_HELD:
    assert property (@(posedge clk) disable iff (!resetn)
        !live[1] |=> div_cnt_q[1] == 16'h0000)
        else $error("disabled divider not held");
    // Divider of a disabled path 0 sits at zero
    AST_DIV_HELD0:
    assert property (@(posedge clk) disable iff (!resetn)
        !live[0] |=> div_cnt_q[0] == 16'h0000)
        else $error("disabled first divider not held");
    // Negative pin clock numbered eight above the stage
    AST_NEG_INDEX:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode == `MODE_DUAL_SE |=> clk_index_q[1] == STAGE_INDEX + 4'h8)
        else $error("negative pin index wrong");
    // Pair clock keeps the stage number
    AST_DIFF_INDEX:
    assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> clk_index_q[0] == STAGE_INDEX)
        else $error("differential index wrong");
    // Pin clock takes the fixed mixed number
    AST_MIXED_INDEX:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode == `MODE_DIFF_PIN |=> clk_index_q[1] == MIXED_INDEX)
        else $error("mixed index wrong");
    // Mixed mode never reached on stages without it
    AST_NO_MIXED:
    assert property (@(posedge clk) disable iff (!resetn)
        !MIXED_OK |-> eff_mode != `MODE_DIFF_PIN)
        else $error("mixed mode on unsupported stage");
    // Receiver type masked for single-ended pins
    AST_RX_SE:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode == `MODE_DUAL_SE |=> !rx_nmos_q)
        else $error("receiver type leaked in single-ended mode");
    // Receiver type passed on when the pair is in use
    AST_RX_PASS:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode != `MODE_DUAL_SE |=> rx_nmos_q == $past(rx_nmos))
        else $error("receiver type not passed to the pair");
    // Bypass forwards every selected edge
    AST_BYPASS:
    assert property (@(posedge clk) disable iff (!resetn)
        edge_hit[0] && path_cfg[0].bypass && !path_cfg[0].sync_role |=> clk_pulse_q[0])
        else $error("bypass dropped an edge");
    // Bypass keeps the divider cleared
    AST_BYPASS_CLEAR:
    assert property (@(posedge clk) disable iff (!resetn)
        path_cfg[0].bypass |=> div_cnt_q[0] == 16'h0000)
        else $error("bypassed divider kept counting");
    // Divider fires only at its threshold
    AST_DIV_RATIO:
    assert property (@(posedge clk) disable iff (!resetn)
        div_out[0] && !path_cfg[0].bypass |-> edge_hit[0] && div_cnt_q[0] >= field_0_chk)
        else $error("divider fired early");
    // Output pulses never run together
    AST_DIV_SPACING:
    assert property (@(posedge clk) disable iff (!resetn)
        clk_pulse_q[0] |=> !clk_pulse_q[0])
        else $error("output pulse longer than one cycle");
    // Path 1 events come only from a selected edge
    AST_DIV_ON_EDGE:
    assert property (@(posedge clk) disable iff (!resetn)
        div_out[1] |-> edge_hit[1])
        else $error("second path event without an edge");
    // Sync role routes the event to the sync output
    AST_SYNC_ROLE:
    assert property (@(posedge clk) disable iff (!resetn)
        div_out[1] && path_cfg[1].sync_role |=> sync_pulse_q[1] && !clk_pulse_q[1])
        else $error("sync role not honoured");
    // Clock and sync outputs of one path never together
    AST_ROLE_EXCL0:
    assert property (@(posedge clk) disable iff (!resetn)
        !(clk_pulse_q[0] && sync_pulse_q[0]))
        else $error("both roles pulsed on the first path");
    // Pin clock in mixed mode is never divided
    AST_PIN_NO_DIV:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode == `MODE_DIFF_PIN && edge_hit[1] && !path_cfg[1].sync_role |=> clk_pulse_q[1])
        else $error("pin clock was divided");
    // Differential only leaves the second path off
    AST_DIFF_ONLY_PATH:
    assert property (@(posedge clk) disable iff (!resetn)
        eff_mode == `MODE_DIFF |=> !path_active_q[1])
        else $error("second path active in differential mode");
    // Enabled path reports itself active
    AST_ACTIVE:
    assert property (@(posedge clk) disable iff (!resetn)
        live[0] |=> path_active_q[0])
        else $error("enabled path not reported active");
    // Nominal frequency copied whole
    AST_FREQ_COPY:
    assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> nominal_freq_q == $past(input_nominal_frequency))
        else $error("nominal frequency not copied");
    // Reported mode follows the effective mode
    AST_MODE_TRACK:
    assert property (@(posedge clk) disable iff (!resetn)
        1'b1 |=> mode_q == $past(eff_mode))
        else $error("reported mode wrong");
    // A selected edge needs a level change on the pin
    AST_EDGE_SEL:
    assert property (@(posedge clk) disable iff (!resetn)
        edge_hit[0] |-> pin_s2_q[0] != pin_s3_q[0])
        else $error("edge seen without a pin change");

    ////////////////////////////////////////////////////////////////////////
    // Coverage of the main scenarios
    // Any clock pulse on the pair path
    COV_DIV_OUT: cover property (@(posedge clk) disable iff (!resetn) clk_pulse_q[0]);
    // Negative pin clock in dual mode
    COV_DUAL: cover property (@(posedge clk) disable iff (!resetn) eff_mode == `MODE_DUAL_SE && clk_pulse_q[1]);
    // Pin clock in mixed mode
    COV_MIXED: cover property (@(posedge clk) disable iff (!resetn) eff_mode == `MODE_DIFF_PIN && clk_pulse_q[1]);
    // Sync role on the pair path
    COV_SYNC: cover property (@(posedge clk) disable iff (!resetn) sync_pulse_q[0]);
    // Divided output on the pair path
    COV_DIVIDED: cover property (@(posedge clk) disable iff (!resetn) div_out[0] && !path_cfg[0].bypass);

endmodule

// ---- tb/ref_clock_source.sv ----
// Model of the external reference clock sources feeding the input pins
module ref_clock_source (
    // Clock and control from the bench
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    // Clock pins towards the stage
    output logic pos_pin,
    output logic neg_pin,
    output logic gpio_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int tick = 0; // Cycles since the burst began
    logic go = 1'h0; // Run as seen at the edge
    initial {pos_pin, neg_pin, gpio_pin} = 3'h0;
    // Bursts at 1, 1/2 and 1/3 of the base rate; pins idle low between bursts
    always @(posedge clk) begin
        go = run;
        #2;
        if (!go) begin
            tick = 0;
            {pos_pin, neg_pin, gpio_pin} = 3'h0;
        end else begin
            if (tick % half == half - 1) pos_pin = ~pos_pin;
            if (tick % (2 * half) == 2 * half - 1) neg_pin = ~neg_pin;
            if (tick % (3 * half) == 3 * half - 1) gpio_pin = ~gpio_pin;
            tick++;
        end
    end
endmodule

// ---- tb/reference_input_stage_tb.sv ----
// Testbench for the reference-clock input stage
module reference_input_stage_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // One table row: mode, two path settings, expected counts and index
    typedef struct packed {
        logic [1:0] mode;
        ref_input_pkg::path_cfg_t c0;
        ref_input_pkg::path_cfg_t c1;
        logic [3:0] e0;
        logic [3:0] e1;
        logic [3:0] es1;
        logic [3:0] idx1;
        logic [1:0] act;
    } row_t;
    logic clk = 1'h0, resetn = 1'h0, run = 1'h0, rx_nmos = 1'h0;
    logic [1:0] mode = 2'h0;
    ref_input_pkg::nominal_freq_t freq = '0;
    ref_input_pkg::path_cfg_t cfg [2] = '{default: '0};
    logic pos, neg, gp, nmos_o;
    logic [1:0] clk_p, sync_p, act_o, mode_o;
    logic [3:0] idx [2];
    ref_input_pkg::nominal_freq_t freq_o;
    int miscompares = 0, comparisons = 0, cycles = 0;
    int ccnt [2], scnt [2];
    row_t rows [8];
    always #12.5 clk = ~clk;
    ref_clock_source ref_clock_source_inst (.clk(clk), .run(run), .half(4'h3), .pos_pin(pos), .neg_pin(neg),
        .gpio_pin(gp));
    ref_input_stage #(.STAGE_INDEX(4'h1), .MIXED_OK(1'h1), .MIXED_INDEX(4'h9)) ref_input_stage_inst (
        .clk(clk), .resetn(resetn), .positive_input_pin(pos), .negative_input_pin(neg), .gpio_input_pin(gp),
        .mode(mode), .rx_nmos(rx_nmos), .input_nominal_frequency(freq), .path_cfg(cfg), .clk_pulse_q(clk_p),
        .sync_pulse_q(sync_p), .clk_index_q(idx), .path_active_q(act_o), .rx_nmos_q(nmos_o), .mode_q(mode_o),
        .nominal_freq_q(freq_o));
    // Pulse counters per path
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            ccnt[i] += clk_p[i];
            scnt[i] += sync_p[i];
        end
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    function automatic ref_input_pkg::path_cfg_t mk(logic inv, logic byp, logic syn, logic [15:0] d);
        return {1'h1, inv, byp, syn, d};
    endfunction
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence: reset, table, then hand-written cases
    initial begin
        rows[0] = '{2'h0, mk(0, 1, 0, 16'h0000), mk(0, 1, 0, 16'h0000), 4'h6, 4'h0, 4'h0, 4'h0, 2'h1};
        rows[1] = '{2'h0, mk(0, 0, 0, 16'h0001), '0, 4'h3, 4'h0, 4'h0, 4'h0, 2'h1};
        rows[2] = '{2'h0, mk(1, 0, 0, 16'h0002), '0, 4'h2, 4'h0, 4'h0, 4'h0, 2'h1};
        rows[3] = '{2'h1, mk(0, 1, 0, 16'h0000), mk(0, 0, 0, 16'h0000), 4'h6, 4'h1, 4'h0, 4'h9, 2'h3};
        rows[4] = '{2'h1, mk(0, 0, 0, 16'hffff), mk(1, 1, 1, 16'h0000), 4'h0, 4'h0, 4'h3, 4'h9, 2'h3};
        rows[5] = '{2'h2, mk(0, 0, 0, 16'h0005), mk(0, 0, 0, 16'h0001), 4'h1, 4'h2, 4'h0, 4'h9, 2'h3};
        rows[6] = '{2'h3, mk(0, 1, 0, 16'h0000), mk(0, 1, 0, 16'h0000), 4'h6, 4'h0, 4'h0, 4'h0, 2'h1};
        rows[7] = '{2'h1, '0, '0, 4'h0, 4'h0, 4'h0, 4'h0, 2'h0};
        step(6);
        chk({clk_p, sync_p, act_o, mode_o, nmos_o}, '0);
        chk(freq_o, '0);
        chk({idx[0], idx[1]}, '0);
        resetn = 1'h1;
        foreach (rows[r]) begin
            cfg = '{default: '0};
            step(2);
            mode = rows[r].mode;
            cfg = '{rows[r].c0, rows[r].c1};
            ccnt = '{0, 0};
            scnt = '{0, 0};
            step(2);
            run = 1'h1;
            step(36);
            run = 1'h0;
            step(8);
            chk(ccnt[0], rows[r].e0);
            chk(ccnt[1], rows[r].e1);
            chk(scnt[1], rows[r].es1);
            chk(act_o, rows[r].act);
            chk(idx[0], 4'h1);
            if (rows[r].act[1]) chk(idx[1], rows[r].idx1);
            $display("test %0d done", r);
        end
        rx_nmos = 1'h1;
        mode = 2'h0;
        freq = {48'hffff_ffff_ffff, 16'h009e};
        step(2);
        chk(nmos_o, 1'h1);
        chk(freq_o, {48'hffff_ffff_ffff, 16'h009e});
        mode = 2'h1;
        step(2);
        chk(nmos_o, 1'h0);
        mode = 2'h3;
        step(2);
        chk(mode_o, 2'h0);
        $display("test settings done");
        mode = 2'h0;
        cfg = '{mk(0, 1, 1, 16'h0000), '0};
        ccnt = '{0, 0};
        scnt = '{0, 0};
        step(2);
        run = 1'h1;
        step(36);
        run = 1'h0;
        step(8);
        chk(scnt[0], 6);
        chk(ccnt[0], 0);
        $display("test sync path done");
        run = 1'h1;
        step(10);
        resetn = 1'h0;
        step(2);
        chk({clk_p, sync_p, act_o, mode_o}, '0);
        resetn = 1'h1;
        step(2);
        chk(act_o, 2'h1);
        run = 1'h0;
        step(8);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule
